/* inc/rbc_pkg.sv */
// Constants and types of the receiver bit check and data output block.
// Assumes a 100 MHz system clock; all slower rates are enable pulses.
package rbc_pkg;

  // System clock and base clock of the polling logic
  localparam int CLK_PERIOD_NS  = 10;
  localparam int BASE_PERIOD_NS = 2000;
  localparam int BASE_DIV       = (BASE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Extended tick: 8, 4, 2 or 1 base ticks, kept as divisor minus one
  localparam logic [2:0] XTICK_DIV_M1 = 3'h7;

  // Bit check
  localparam logic [4:0] CHECKS_PER_BIT = 5'h02;
  localparam logic [4:0] BITS_PER_STEP  = 5'h03;
  localparam int         LIMIT_W        = 6;
  localparam logic [5:0] LOWER_LIMIT_RST = 6'h0e;
  localparam logic [5:0] UPPER_LIMIT_RST = 6'h18;

  // Operating configuration fields and reset values
  localparam int         OPC_W          = 11;
  localparam int         OPC_BAUD_LSB   = 9;
  localparam int         OPC_BITS_LSB   = 7;
  localparam int         OPC_SLEEP_LSB  = 2;
  localparam int         OPC_STD_BIT    = 1;
  localparam int         OPC_TEMP_BIT   = 0;
  localparam logic [1:0] BAUD_RST       = 2'h0;
  localparam logic [1:0] BITS_RST       = 2'h2;
  localparam logic [4:0] SLEEP_RST      = 5'h0b;
  localparam logic [4:0] SLEEP_FOREVER  = 5'h1f;

  // Timing counts, in extended ticks unless named otherwise
  localparam logic [7:0]  STARTUP_TICKS  = 8'h10;
  localparam logic [7:0]  HOLD_IN_TICKS  = 8'h08;
  localparam logic [7:0]  HOLD_OUT_TICKS = 8'h0b;
  localparam logic [7:0]  MAX_LOW_TICKS  = 8'h50;
  localparam logic [7:0]  OFF_LOW_TICKS  = 8'h14;
  localparam logic [7:0]  SYNC_TICKS     = 8'h04;
  localparam int          SLEEP_UNIT_LOG2 = 10;
  localparam int          SLEEP_EXT_LOG2  = 3;
  localparam int          SLEEP_CNT_W     = 18;

  // Sample buffer
  localparam int FIFO_WIDTH = 1;
  localparam int FIFO_DEPTH = 16;

  // Operating states
  typedef enum logic [2:0] {
    RBC_SLEEP   = 3'h0,
    RBC_STARTUP = 3'h1,
    RBC_CHECK   = 3'h2,
    RBC_RECEIVE = 3'h3,
    RBC_OFF_CMD = 3'h4
  } rbc_state_type;

endpackage

/* rtl/rbc_tick_gen.sv */
// Base clock and extended tick enables for the bit check block.
// Assumes one clock; the baud range input is a registered setting.
`timescale 1ns/100ps
module rbc_tick_gen (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [1:0] baud_range_select,
  output logic            base_tick,
  output logic            extended_tick
);

  localparam int DIV_W = $clog2(rbc_pkg::BASE_DIV);

  logic [DIV_W-1:0] div_reg;
  logic [2:0]       xcnt_reg;
  wire              div_wrap  = (div_reg == DIV_W'(rbc_pkg::BASE_DIV - 1));
  wire  [2:0]       xdiv_m1   = rbc_pkg::XTICK_DIV_M1 >> baud_range_select;
  wire              xcnt_wrap = (xcnt_reg >= xdiv_m1);

  ////////////////////////////////////////////////////////////////////////////
  // Base divider, then 8/4/2/1 base ticks per extended tick
  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_reg  <= '0;
      xcnt_reg <= 3'h0;
    end else begin
      div_reg <= div_wrap ? '0 : div_reg + 1'b1;
      if (div_wrap) begin
        xcnt_reg <= xcnt_wrap ? 3'h0 : xcnt_reg + 3'h1;
      end
    end
  end

  assign base_tick     = div_wrap;
  assign extended_tick = div_wrap && xcnt_wrap;

endmodule // rbc_tick_gen

/* rtl/rbc_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes writer and reader share the clock; DEPTH is a power of two.
`timescale 1ns/100ps
module rbc_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic [WIDTH-1:0]      rd_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr_reg;
  logic [AW:0]      rptr_reg;
  wire              full  = (wptr_reg[AW] != rptr_reg[AW]) &&
                            (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
  wire              empty = (wptr_reg == rptr_reg);
  wire              push  = wr_valid && !full;
  wire              pop   = rd_ready && !empty;

  ////////////////////////////////////////////////////////////////////////////
  // Extra pointer bit tells full from empty without a counter
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (push) wptr_reg <= wptr_reg + 1'b1;
      if (pop)  rptr_reg <= rptr_reg + 1'b1;
    end
  end

  // Storage is not reset; empty keeps stale words from being read
  always_ff @(posedge clk) begin
    if (push) mem[wptr_reg[AW-1:0]] <= wr_data;
  end

  assign wr_ready = !full;
  assign rd_valid = !empty;
  assign rd_data  = mem[rptr_reg[AW-1:0]];

endmodule // rbc_fifo

/* rtl/rbc_bit_check.sv */
// Wake-up qualifier and data pin conditioner of a polling RF receiver.
// Assumes asynchronous demodulator, enable and data pin inputs, and an
// open-drain data pin with an external pull-up.
`timescale 1ns/100ps

// Operation
// - Two edge-to-edge interval checks verify one bit.
// - Bit count setting selects 0, 3, 6 or 9 bits, so 0/6/12/18 checks.
// - Spacing inside window continues checking; outside it aborts to sleep.
// - Window spans lower limit to upper limit minus one extended ticks.
// - Both limits live as fields of the bound window register.
// - Upper limits up to 63 are accepted.
// - Limits reset to 14 and 24.
// - Demodulator ignored during startup; counter advances per extended tick.
// - Fail on edge below lower limit, or when counter reaches upper limit.
// - All bits passed: enter receiving mode and drive data pin.
// - Receiving mode holds until data pin or enable pin sends it back.
// - Demodulator sampled per extended tick; output edges on tick boundaries.
// - After an output edge, level frozen for in-window or out-window hold.
// - Continuous low level on the data output limited to a maximum time.
// - After transmission, stay receiving and pass noise to the data pin.
// - Off command issues exactly one sync pulse, then the sleep period.
// - Low enable pulse; sleep starts at rising edge, held while low.
// - Extended tick is 8, 4, 2 or 1 base ticks by baud range.
// - A failed check clears the temporary sleep extension bit.
module rbc_bit_check (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       demod_output,
  input  wire logic       enable_pin,
  input  wire logic       data_pin_in,
  output logic            data_pin_out,
  output logic            data_pin_oe,
  input  wire logic       cfg_load,
  input  wire logic [1:0] baud_range_select,
  input  wire logic [1:0] bits_to_check,
  input  wire logic [4:0] sleep_value,
  input  wire logic       sleep_ext_std,
  input  wire logic       temporary_sleep_extension,
  input  wire logic [5:0] lower_limit_count,
  input  wire logic [5:0] upper_limit_count,
  input  wire logic       overrun_clear,
  output logic [2:0]      mode_code,
  output logic            receiving,
  output logic            temp_ext_active,
  output logic            sample_overrun
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [rbc_pkg::OPC_W-1:0]     operating_config_reg;
  logic [2*rbc_pkg::LIMIT_W-1:0] bound_window_reg;

  wire [1:0] baud_sel  = operating_config_reg[rbc_pkg::OPC_BAUD_LSB +: 2];
  wire [1:0] bits_sel  = operating_config_reg[rbc_pkg::OPC_BITS_LSB +: 2];
  wire [4:0] sleep_sel = operating_config_reg[rbc_pkg::OPC_SLEEP_LSB +: 5];
  wire       ext_std   = operating_config_reg[rbc_pkg::OPC_STD_BIT];
  wire       ext_temp  = operating_config_reg[rbc_pkg::OPC_TEMP_BIT];
  wire [5:0] lower_lim = bound_window_reg[rbc_pkg::LIMIT_W +: rbc_pkg::LIMIT_W];
  wire [5:0] upper_lim = bound_window_reg[0 +: rbc_pkg::LIMIT_W];

  logic temp_clr;

  // A load wins over the automatic clear of the temporary extension bit
  always_ff @(posedge clk) begin
    if (!resetn) begin
      operating_config_reg <= {rbc_pkg::BAUD_RST, rbc_pkg::BITS_RST,
                               rbc_pkg::SLEEP_RST, 1'b0, 1'b0};
      bound_window_reg     <= {rbc_pkg::LOWER_LIMIT_RST,
                               rbc_pkg::UPPER_LIMIT_RST};
    end else if (cfg_load) begin
      operating_config_reg <= {baud_range_select, bits_to_check, sleep_value,
                               sleep_ext_std, temporary_sleep_extension};
      bound_window_reg     <= {lower_limit_count, upper_limit_count};
    end else if (temp_clr) begin
      operating_config_reg[rbc_pkg::OPC_TEMP_BIT] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage is read

  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic       en_prev_reg;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= {data_pin_in, enable_pin, demod_output};
      sync2_reg <= sync1_reg;
    end
  end

  wire demod_s = sync2_reg[0];
  wire en_s    = sync2_reg[1];
  wire pin_s   = sync2_reg[2];
  wire en_rise = en_s && !en_prev_reg;

  always_ff @(posedge clk) begin
    if (!resetn) en_prev_reg <= 1'b0;
    else         en_prev_reg <= en_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timing and the per-tick sample buffer

  logic base_tick;
  logic extended_tick;
  logic fifo_wr_ready;
  logic fifo_rd_valid;
  logic fifo_rd_data;
  logic fifo_rd_ready;

  rbc_tick_gen u_tick (
    .clk               (clk),
    .resetn            (resetn),
    .baud_range_select (baud_sel),
    .base_tick         (base_tick),
    .extended_tick     (extended_tick)
  );

  // One word per extended tick, so each popped word is one tick of time
  rbc_fifo #(
    .WIDTH (rbc_pkg::FIFO_WIDTH),
    .DEPTH (rbc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .resetn   (resetn),
    .wr_valid (extended_tick),
    .wr_ready (fifo_wr_ready),
    .wr_data  (demod_s),
    .rd_valid (fifo_rd_valid),
    .rd_ready (fifo_rd_ready),
    .rd_data  (fifo_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State and counters

  rbc_pkg::rbc_state_type state_reg;
  rbc_pkg::rbc_state_type state_next;

  logic [rbc_pkg::SLEEP_CNT_W-1:0] sleep_cnt_reg;
  logic [7:0]                      phase_cnt_reg;
  logic                            sync_active_reg;
  logic [5:0]                      edge_interval_count_reg;
  logic [4:0]                      check_cnt_reg;
  logic                            synced_reg;
  logic                            last_demod_reg;
  logic                            out_level_reg;
  logic [7:0]                      out_gap_reg;
  logic                            in_win_reg;
  logic                            low_block_reg;
  logic [7:0]                      off_cnt_reg;
  logic                            overrun_reg;

  // Popping every cycle turns the buffer into a delayed, evenly spaced tick stream
  assign fifo_rd_ready = 1'b1;

  wire tick   = fifo_rd_valid;
  wire sample = fifo_rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // Sleep length in base ticks; the top code never expires

  wire                            ext_any      = ext_std || ext_temp;
  wire [rbc_pkg::SLEEP_CNT_W-1:0] sleep_base   = {13'h0, sleep_sel} << rbc_pkg::SLEEP_UNIT_LOG2;
  wire [rbc_pkg::SLEEP_CNT_W-1:0] sleep_target = ext_any ?
                                                 sleep_base << rbc_pkg::SLEEP_EXT_LOG2 :
                                                 sleep_base;
  wire                            sleep_done   = (sleep_sel != rbc_pkg::SLEEP_FOREVER) &&
                                                 (sleep_cnt_reg >= sleep_target);

  // Startup ignores the demodulator; only the tick count matters
  wire su_done = tick && (phase_cnt_reg + 8'h01 >= rbc_pkg::STARTUP_TICKS);

  ////////////////////////////////////////////////////////////////////////////
  // Bit check decode

  // Two interval checks per bit, three bits per setting step
  wire [4:0] checks_needed = {3'h0, bits_sel} * rbc_pkg::BITS_PER_STEP *
                             rbc_pkg::CHECKS_PER_BIT;
  wire       demod_edge    = sample != last_demod_reg;
  wire [6:0] spacing       = {1'b0, edge_interval_count_reg} + 7'h01;

  // Reaching the upper count fails even without an edge, so a dead line cannot hang
  wire chk_over  = spacing >= {1'b0, upper_lim};
  wire chk_under = demod_edge && synced_reg &&
                   (spacing < {1'b0, lower_lim});
  wire chk_fail  = tick && (chk_over || chk_under);
  wire chk_pass  = tick && demod_edge && synced_reg && !chk_fail;
  wire chk_last  = chk_pass && (check_cnt_reg + 5'h01 >= checks_needed);

  // Load wins: a failing check clears the temporary extension unless a load lands
  assign temp_clr = (state_reg == rbc_pkg::RBC_CHECK) && en_s && chk_fail;

  ////////////////////////////////////////////////////////////////////////////
  // Data output decode

  wire [7:0] out_spacing = out_gap_reg + 8'h01;
  wire [7:0] hold_need   = in_win_reg ? rbc_pkg::HOLD_IN_TICKS :
                                        rbc_pkg::HOLD_OUT_TICKS;

  // A cut low run stays high until the demodulator has been high once again
  wire force_high = !out_level_reg &&
                    (out_spacing >= rbc_pkg::MAX_LOW_TICKS);
  wire follow     = (sample != out_level_reg) && (out_spacing >= hold_need) &&
                    !(low_block_reg && !sample);
  wire out_flip   = tick && (force_high || follow);
  wire spacing_in = (out_spacing >= {2'h0, lower_lim}) &&
                    (out_spacing < {2'h0, upper_lim});

  // Host pulling a released line low is the only way the pin reads low while high
  wire off_hit   = tick && out_level_reg && !pin_s &&
                   (off_cnt_reg + 8'h01 >= rbc_pkg::OFF_LOW_TICKS);
  wire sync_done = tick && sync_active_reg &&
                   (phase_cnt_reg + 8'h01 >= rbc_pkg::SYNC_TICKS);

  ////////////////////////////////////////////////////////////////////////////
  // Next state; a low enable overrides every state

  always_comb begin
    state_next = state_reg;
    if (!en_s) begin
      state_next = rbc_pkg::RBC_SLEEP;
    end else begin
      case (state_reg)
        rbc_pkg::RBC_SLEEP: begin
          if (sleep_done) state_next = rbc_pkg::RBC_STARTUP;
        end
        rbc_pkg::RBC_STARTUP: begin
          if (su_done) begin
            state_next = (bits_sel == 2'h0) ? rbc_pkg::RBC_RECEIVE :
                                              rbc_pkg::RBC_CHECK;
          end
        end
        rbc_pkg::RBC_CHECK: begin
          if (chk_fail)      state_next = rbc_pkg::RBC_SLEEP;
          else if (chk_last) state_next = rbc_pkg::RBC_RECEIVE;
        end
        rbc_pkg::RBC_RECEIVE: begin
          if (off_hit) state_next = rbc_pkg::RBC_OFF_CMD;
        end
        rbc_pkg::RBC_OFF_CMD: begin
          if (sync_done) state_next = rbc_pkg::RBC_SLEEP;
        end
        default: begin
          state_next = rbc_pkg::RBC_SLEEP;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!resetn) state_reg <= rbc_pkg::RBC_SLEEP;
    else         state_reg <= state_next;
  end

  // Sleep restarts from zero at the enable rising edge
  always_ff @(posedge clk) begin
    if (!resetn || state_reg != rbc_pkg::RBC_SLEEP || !en_s || en_rise) begin
      sleep_cnt_reg <= '0;
    end else if (base_tick && !sleep_done) begin
      sleep_cnt_reg <= sleep_cnt_reg + 1'b1;
    end
  end

  // Startup and sync pulse share one tick counter
  always_ff @(posedge clk) begin
    if (!resetn || state_next != state_reg) begin
      phase_cnt_reg   <= 8'h00;
      sync_active_reg <= 1'b0;
    end else begin
      if (tick && (state_reg == rbc_pkg::RBC_STARTUP || sync_active_reg)) begin
        phase_cnt_reg <= phase_cnt_reg + 8'h01;
      end
      // Single sync pulse once the host has let go of the line
      if (state_reg == rbc_pkg::RBC_OFF_CMD && pin_s) sync_active_reg <= 1'b1;
    end
  end

  // Interval counter; the first edge only aligns it
  always_ff @(posedge clk) begin
    if (!resetn || state_reg != rbc_pkg::RBC_CHECK) begin
      edge_interval_count_reg <= 6'h00;
      check_cnt_reg           <= 5'h00;
      synced_reg              <= 1'b0;
    end else if (tick) begin
      edge_interval_count_reg <= demod_edge ? 6'h00 :
                                 edge_interval_count_reg + 6'h01;
      if (demod_edge) synced_reg <= 1'b1;
      if (chk_pass)   check_cnt_reg <= check_cnt_reg + 5'h01;
    end
  end

  // Previous tick sample, for edge detection
  always_ff @(posedge clk) begin
    if (!resetn)   last_demod_reg <= 1'b0;
    else if (tick) last_demod_reg <= sample;
  end

  // Conditioned data; starts high so the first wake edge is a fall
  always_ff @(posedge clk) begin
    if (!resetn || state_reg != rbc_pkg::RBC_RECEIVE) begin
      out_level_reg <= 1'b1;
      out_gap_reg   <= 8'h00;
      in_win_reg    <= 1'b0;
      low_block_reg <= 1'b0;
      off_cnt_reg   <= 8'h00;
    end else if (tick) begin
      out_gap_reg   <= out_flip ? 8'h00 :
                       (out_gap_reg == 8'hfe) ? out_gap_reg : out_spacing;
      off_cnt_reg   <= (out_level_reg && !pin_s) ? off_cnt_reg + 8'h01 : 8'h00;
      low_block_reg <= force_high || (low_block_reg && !sample);
      if (out_flip) begin
        out_level_reg <= !out_level_reg;
        in_win_reg    <= spacing_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered; all but temp_ext_active come from the same state so they stay in step

  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_code       <= rbc_pkg::RBC_SLEEP;
      receiving       <= 1'b0;
      data_pin_out    <= 1'b1;
      data_pin_oe     <= 1'b0;
      temp_ext_active <= 1'b0;
    end else begin
      mode_code       <= state_reg;
      receiving       <= state_reg == rbc_pkg::RBC_RECEIVE;
      data_pin_out    <= (state_reg == rbc_pkg::RBC_RECEIVE) ? out_level_reg :
                                                               !sync_active_reg;
      data_pin_oe     <= (state_reg == rbc_pkg::RBC_RECEIVE) || sync_active_reg;
      temp_ext_active <= ext_temp;
    end
  end

  // Overrun flag; a full buffer loses time, so the set wins over the clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      overrun_reg <= 1'b0;
    end else if (extended_tick && !fifo_wr_ready) begin
      overrun_reg <= 1'b1;
    end else if (overrun_clear) begin
      overrun_reg <= 1'b0;
    end
  end

  assign sample_overrun = overrun_reg;

endmodule // rbc_bit_check

/* tb/rbc_bit_check_asserts.sv */
// Port checker of the bit check block, bound to every instance of it.
// Assumes 100 MHz; one extended tick is never shorter than 200 cycles.
`timescale 1ns/100ps
module rbc_bit_check_asserts (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       enable_pin,
  input wire logic       data_pin_out,
  input wire logic       data_pin_oe,
  input wire logic       cfg_load,
  input wire logic [2:0] mode_code,
  input wire logic       receiving,
  input wire logic       temp_ext_active
);
  localparam int LOW_MAX  = 129600;
  localparam int HOLD_MIN = 1500;
  localparam int SU_MIN   = 3000;
  logic [17:0] low_cnt_reg;
  logic [17:0] same_cnt_reg;
  logic [17:0] su_cnt_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Cycle counters; loose bounds cover the slowest tick
  always_ff @(posedge clk) begin
    if (!resetn) begin
      low_cnt_reg  <= 18'h0;
      same_cnt_reg <= 18'h0;
      su_cnt_reg   <= 18'h0;
    end else begin
      low_cnt_reg  <= (data_pin_oe && !data_pin_out) ? low_cnt_reg + 18'h1 : 18'h0;
      same_cnt_reg <= $changed(data_pin_out) ? 18'h0 : same_cnt_reg + 18'h1;
      su_cnt_reg   <= (mode_code == rbc_pkg::RBC_STARTUP) ? su_cnt_reg + 18'h1 : 18'h0;
    end
  end
  sequence en_low_s;
    !enable_pin [*8];
  endsequence
  sequence leave_s(logic [2:0] st);
    mode_code == st ##1 mode_code != st;
  endsequence
  a_oe_in_rx: assert property (
    data_pin_oe |-> mode_code inside {rbc_pkg::RBC_RECEIVE, rbc_pkg::RBC_OFF_CMD})
    else $error("data pin driven outside receiving");
  a_rx_state: assert property (
    receiving |-> mode_code == rbc_pkg::RBC_RECEIVE) else $error("receiving flag off state");
  a_en_sleep: assert property (
    en_low_s |-> mode_code == rbc_pkg::RBC_SLEEP && !receiving) else $error("awake, enable low");
  a_low_limit: assert property (
    low_cnt_reg <= LOW_MAX) else $error("data low too long");
  a_freeze_min: assert property (
    $changed(data_pin_out) && mode_code == rbc_pkg::RBC_RECEIVE && $past(receiving)
    |-> same_cnt_reg >= HOLD_MIN) else $error("data edge inside freeze time");
  a_temp_clear: assert property (
    $fell(temp_ext_active) && !$past(cfg_load) |-> $past(mode_code) == rbc_pkg::RBC_CHECK
    || $past(mode_code, 2) == rbc_pkg::RBC_CHECK) else $error("extension cleared outside check");
  a_rx_entry: assert property (
    $rose(receiving) |-> $past(mode_code) inside {rbc_pkg::RBC_STARTUP, rbc_pkg::RBC_CHECK})
    else $error("receiving entered from wrong mode");
  a_check_exit: assert property (
    leave_s(rbc_pkg::RBC_CHECK) |-> mode_code inside {rbc_pkg::RBC_SLEEP, rbc_pkg::RBC_RECEIVE})
    else $error("check left to wrong mode");
  a_startup_len: assert property (
    leave_s(rbc_pkg::RBC_STARTUP) |-> su_cnt_reg >= SU_MIN || mode_code == rbc_pkg::RBC_SLEEP)
    else $error("startup too short");
endmodule // rbc_bit_check_asserts

bind rbc_bit_check rbc_bit_check_asserts u_rbc_bit_check_asserts (.clk(clk), .resetn(resetn),
  .enable_pin(enable_pin), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
  .cfg_load(cfg_load), .mode_code(mode_code), .receiving(receiving),
  .temp_ext_active(temp_ext_active));

/* tb/rbc_host_model.sv */
// Host and transmitter model at the far side of the data and enable pins.
// Assumes an external pull-up on the open-drain data line.
`timescale 1ns/100ps
module rbc_host_model (
  input  wire logic        clk,
  input  wire logic        dev_out,
  input  wire logic        dev_oe,
  input  wire logic        host_low,
  input  wire logic        host_enable,
  input  wire logic [15:0] half_cycles,
  output logic             demod_output,
  output logic             enable_pin,
  output logic             data_line
);
  logic [15:0] cnt = 16'h0;
  initial demod_output = 1'b0;
  // Transmitter edges at a fixed spacing; zero parks the line low
  always @(posedge clk) begin
    if (half_cycles == 16'h0 || cnt + 16'h1 >= half_cycles) begin
      cnt <= 16'h0;
      demod_output <= (half_cycles == 16'h0) ? 1'b0 : !demod_output;
    end else begin
      cnt <= cnt + 16'h1;
    end
  end
  // Wired-and line: either party pulling low wins over the pull-up
  assign data_line  = !((dev_oe && !dev_out) || host_low);
  assign enable_pin = host_enable;
endmodule // rbc_host_model

/* tb/rbc_bit_check_tb_top.sv */
// Self-checking bench of the bit check block with its host model.
// Assumes baud range 3 and sleep 0, so one extended tick is 200 cycles.
`timescale 1ns/100ps
module rbc_bit_check_tb_top;
  localparam int TICK = 200;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        cfg_load = 1'b0;
  logic [1:0]  bits = 2'h0;
  logic        temp_ext = 1'b0;
  logic [5:0]  lo = 6'h0e;
  logic        host_low = 1'b0;
  logic        host_en = 1'b1;
  logic [15:0] half = 16'h0;
  logic        demod, en_pin, data_line, dout, doe, rx, temp_act;
  logic [2:0]  mode;
  int          n_errors = 0;
  int          tests_run = 0;
  int          low_run = 0;
  int          max_low = 0;
  always #5 clk = !clk;
  rbc_bit_check u_rbc_bit_check (.clk(clk), .resetn(resetn), .demod_output(demod),
    .enable_pin(en_pin), .data_pin_in(data_line), .data_pin_out(dout), .data_pin_oe(doe),
    .cfg_load(cfg_load), .baud_range_select(2'h3), .bits_to_check(bits), .sleep_value(5'h00),
    .sleep_ext_std(1'b0), .temporary_sleep_extension(temp_ext), .lower_limit_count(lo),
    .upper_limit_count(6'h18), .overrun_clear(1'b0), .mode_code(mode), .receiving(rx),
    .temp_ext_active(temp_act), .sample_overrun());
  rbc_host_model u_rbc_host_model (.clk(clk), .dev_out(dout), .dev_oe(doe),
    .host_low(host_low), .host_enable(host_en), .half_cycles(half),
    .demod_output(demod), .enable_pin(en_pin), .data_line(data_line));
  // Longest driven low run on the data pin
  always @(posedge clk) begin
    low_run <= (doe && !dout) ? low_run + 1 : 0;
    if (low_run > max_low) max_low <= low_run;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Bounded wait on the receiving flag, then compare
  task automatic wait_rx(input logic exp, input int max_cyc);
    int i;
    for (i = 0; i < max_cyc && rx !== exp; i++) @(posedge clk);
    check("receiving", {7'h0, exp}, {7'h0, rx});
  endtask
  task automatic load(input logic [1:0] b, input logic t);
    bits <= b;
    temp_ext <= t;
    cfg_load <= 1'b1;
    cyc(1);
    cfg_load <= 1'b0;
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(3);
    resetn <= 1'b1;
    cyc(1);
    load(2'h0, 1'b0);
    wait_rx(1'b1, 30 * TICK);
    check("data_pin_oe", 8'h1, {7'h0, doe});
    $display("test zero_bits done");
    // Demodulator stuck low: low run is cut, receiving holds
    cyc(100 * TICK);
    check("wake_edge", 8'h1, {7'h0, max_low > 0});
    check("low_limit", 8'h1, {7'h0, max_low <= 81 * TICK});
    check("data_pin_out", 8'h1, {7'h0, dout});
    check("receiving", 8'h1, {7'h0, rx});
    $display("test stuck_low done");
    host_low <= 1'b1;
    wait_rx(1'b0, 30 * TICK);
    host_low <= 1'b0;
    wait_rx(1'b1, 40 * TICK);
    $display("test data_off done");
    host_en <= 1'b0;
    cyc(20);
    check("mode_code", {5'h0, rbc_pkg::RBC_SLEEP}, {5'h0, mode});
    host_en <= 1'b1;
    wait_rx(1'b1, 30 * TICK);
    $display("test enable_off done");
    // Spacing of 5 ticks is below the window: never qualifies
    load(2'h1, 1'b1);
    half <= 16'h03e8;
    host_en <= 1'b0;
    cyc(20);
    host_en <= 1'b1;
    cyc(60 * TICK);
    check("receiving", 8'h0, {7'h0, rx});
    check("temp_ext_active", 8'h0, {7'h0, temp_act});
    $display("test short_spacing done");
    // Spacing of 18 ticks sits inside 14..23: three bits pass
    half <= 16'h0e10;
    wait_rx(1'b1, 200 * TICK);
    $display("test valid_bits done");
    finish_test();
  end
  initial begin
    cyc(99000);
    n_errors++;
    $display("watchdog expired");
    finish_test();
  end
endmodule // rbc_bit_check_tb_top
